/* File: src/bsw_supply.sv */
// Battery switchover control and supply-monitor event collection.
// Assumes comparators, ADCs and sag detector sit outside and report as inputs.
// Functional notes
// - Switchover on after reset; config bit disables
// - Status bit six shows main supply source
// - Select 01 switches on low dc sense
// - Select 00 switches on low main supply
// - Pin falling edge forces battery when enabled
// - Return needs main ok, dc ok too with select 01
// - Enabled pin must be high to return
// - Source change never stalls the core
// - Metering ADCs unavailable while on battery
// - Master interrupt enable off after reset
// - One shared request, per-event enables, latched flags
// - Main to battery sets switchover flag
// - Battery to main sets restored flag
// - Flags set regardless; cleared by writing zero
// - Dc-sense change beyond threshold raises event
// - Periodic or software conversion; ready flag
// - Battery result or low level sets flag; here only a result sets it, whether low or not
// - Dc-sense below level sets low flag
// - Line sag report sets sag flag
// - Return to main after 130 ms delay
// - Dc-sense switchover after 30 ms delay
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module bsw_supply import bsw_pkg::*; #(
   parameter int unsigned DCIN_DELAY_CYC = BSW_DCIN_DELAY_CYC,
   parameter int unsigned RESTORE_DELAY_CYC = BSW_RESTORE_DELAY_CYC,
   parameter int unsigned BG_PERIOD_CYC = BSW_BG_PERIOD_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic VDD_OK,
   input wire logic DCIN_OK,
   input wire logic BATTERY_CONTROL_PIN,
   input wire logic [7:0] DCIN_ADC_VALUE,
   input wire logic DCIN_ADC_READY,
   input wire logic [7:0] BAT_ADC_VALUE,
   input wire logic BAT_ADC_READY,
   input wire logic LINE_SAG_EVENT,
   output logic SUPPLY_ON_MAIN,
   output logic METER_ADC_AVAILABLE,
   output logic ADC_START,
   output logic SUPPLY_IRQ
);

   function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
      reg_hit = (addr == {2'b00, idx, 2'b00});
   endfunction

   function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction

   // Registers
   logic [7:0] core_irq_en_r, event_en_r, peripheral_configuration_cfg_r, switch_cfg_r;
   logic [7:0] event_flags_r, pin_cfg_r, delta_thr_r, bat_thr_r;
   logic [7:0] event_flags_nxt;
   logic [7:0] bat_value_r, dc_value_r, dc_last_r;
   logic dc_ready_r, dc_ready_nxt;
   logic [31:0] prdata_nxt;
   logic pslverr_nxt;
   bsw_state_t state_r, state_nxt;
   logic [31:0] wait_cnt_r, wait_cnt_nxt;
   logic [31:0] bg_cnt_r;
   logic ctl_pin_prev_r;
   logic src_main_r;

   // Synchronised comparator and pin levels
   logic [2:0] sync_s;
   bsw_sync #(.W(3), .RST_VAL(3'b111)) u_sync (
      .clk(CLK_SYS),
      .rst(RESET),
      .d_in({BATTERY_CONTROL_PIN, DCIN_OK, VDD_OK}),
      .q_out(sync_s)
   );
   wire vdd_ok_s = sync_s[0];
   wire dcin_ok_s = sync_s[1];
   wire ctl_pin_s = sync_s[2];

   // Bus decode
   wire setup_ph = PSEL & ~PENABLE;
   wire wr_en = PSEL & PENABLE & PWRITE & PREADY;
   wire [7:0] wdata = PWDATA[7:0];
   wire wr_core_irq = wr_en & reg_hit(PADDR, BSW_IDX_CORE_IRQ_EN);
   wire wr_event_en = wr_en & reg_hit(PADDR, BSW_IDX_EVENT_EN);
   wire wr_peripheral_configuration = wr_en & reg_hit(PADDR, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG);
   wire wr_switch = wr_en & reg_hit(PADDR, BSW_IDX_SWITCH_CFG);
   wire wr_flags = wr_en & reg_hit(PADDR, BSW_IDX_EVENT_FLAGS);
   wire wr_pin = wr_en & reg_hit(PADDR, BSW_IDX_PIN_CFG);
   wire wr_delta = wr_en & reg_hit(PADDR, BSW_IDX_DELTA_THR);
   wire wr_adc_go = wr_en & reg_hit(PADDR, BSW_IDX_ADC_START);
   wire wr_bat_thr = wr_en & reg_hit(PADDR, BSW_IDX_BAT_THR);
   wire wr_dc_status = wr_en & reg_hit(PADDR, BSW_IDX_DC_STATUS);

   // Switchover configuration
   wire sw_disabled = switch_cfg_r[BSW_SW_DISABLE_BIT];
   wire [1:0] src_sel = switch_cfg_r[BSW_SRC_SEL_LSB +: 2];
   wire dcin_sel = (src_sel == BSW_SEL_DCIN);
   wire pin_en = (pin_cfg_r[BSW_INT1_FN_LSB +: 2] == BSW_INT1_FN_PIN);
   wire ctl_pin_fall = pin_en & ctl_pin_prev_r & ~ctl_pin_s;
   wire force_bat = ctl_pin_fall | ~vdd_ok_s;
   wire restore_ok = vdd_ok_s & (~dcin_sel | dcin_ok_s) & (~pin_en | ctl_pin_s);
   wire dcin_done = (wait_cnt_r == 32'(DCIN_DELAY_CYC - 1));
   wire restore_done = (wait_cnt_r == 32'(RESTORE_DELAY_CYC - 1));

   // Switchover state machine; the source only changes state, the core keeps running
   always_comb begin
      state_nxt = state_r;
      wait_cnt_nxt = wait_cnt_r + 32'd1;
      case (state_r)
         BSW_ON_MAIN: begin
            if (sw_disabled) begin
               state_nxt = BSW_ON_MAIN;
            end else if (force_bat) begin
               state_nxt = BSW_ON_BAT;
            end else if (dcin_sel && !dcin_ok_s) begin
               state_nxt = BSW_DCIN_WAIT;
               wait_cnt_nxt = 32'd0;
            end
         end
         BSW_DCIN_WAIT: begin
            if (sw_disabled || !dcin_sel || dcin_ok_s) begin
               state_nxt = BSW_ON_MAIN;
            end else if (force_bat || dcin_done) begin
               state_nxt = BSW_ON_BAT;
            end
         end
         BSW_ON_BAT: begin
            if (sw_disabled) begin
               state_nxt = BSW_ON_MAIN;
            end else if (restore_ok) begin
               state_nxt = BSW_RESTORING;
               wait_cnt_nxt = 32'd0;
            end
         end
         BSW_RESTORING: begin
            if (sw_disabled) begin
               state_nxt = BSW_ON_MAIN;
            end else if (!restore_ok || ctl_pin_fall) begin
               state_nxt = BSW_ON_BAT;
            end else if (restore_done) begin
               state_nxt = BSW_ON_MAIN;
            end
         end
         default: state_nxt = BSW_ON_MAIN;
      endcase
   end

   wire src_main_nxt = (state_nxt == BSW_ON_MAIN) || (state_nxt == BSW_DCIN_WAIT);
   wire ev_switch = src_main_r & ~src_main_nxt;
   wire ev_restore = ~src_main_r & src_main_nxt;

   // Monitor events; every new battery result qualifies, a low one included
   wire bat_low = (BAT_ADC_VALUE < bat_thr_r);
   wire ev_bat = BAT_ADC_READY;
   wire ev_dc_adc = DCIN_ADC_READY & (abs_diff(DCIN_ADC_VALUE, dc_last_r) > delta_thr_r);
   wire ev_dc_low = ~dcin_ok_s;
   wire ev_sag = LINE_SAG_EVENT;

   logic [7:0] flag_set;
   always_comb begin
      flag_set = 8'h00;
      flag_set[BSW_EV_BAT] = ev_bat;
      flag_set[BSW_EV_DC_ADC] = ev_dc_adc;
      flag_set[BSW_EV_DC_LOW] = ev_dc_low;
      flag_set[BSW_EV_SAG] = ev_sag;
      flag_set[BSW_EV_RESTORE] = ev_restore;
      flag_set[BSW_EV_SWITCH] = ev_switch;
   end

   // Writing 0 clears a flag, writing 1 keeps it; a new event wins over the clear
   wire [7:0] flag_keep = wr_flags ? wdata : 8'hff;
   assign event_flags_nxt = (event_flags_r & flag_keep) | flag_set;
   assign dc_ready_nxt = (dc_ready_r & ~(wr_dc_status & ~wdata[BSW_DC_READY_BIT]))
                         | DCIN_ADC_READY;

   wire irq_nxt = core_irq_en_r[BSW_MASTER_EN_BIT] & |(event_flags_r & event_en_r);
   wire bg_wrap = (bg_cnt_r == 32'(BG_PERIOD_CYC - 1));
   wire adc_go_nxt = (wr_adc_go & wdata[BSW_ADC_GO_BIT]) | bg_wrap;

   // Read mux, sampled in the setup cycle and presented in the access cycle
   always_comb begin
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (reg_hit(PADDR, BSW_IDX_CORE_IRQ_EN)) begin
         prdata_nxt[7:0] = core_irq_en_r;
      end else if (reg_hit(PADDR, BSW_IDX_EVENT_EN)) begin
         prdata_nxt[7:0] = event_en_r;
      end else if (reg_hit(PADDR, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG)) begin
         prdata_nxt[7:0] = peripheral_configuration_cfg_r;
         prdata_nxt[BSW_SRC_STATUS_BIT] = src_main_r;
      end else if (reg_hit(PADDR, BSW_IDX_SWITCH_CFG)) begin
         prdata_nxt[7:0] = switch_cfg_r;
      end else if (reg_hit(PADDR, BSW_IDX_EVENT_FLAGS)) begin
         prdata_nxt[7:0] = event_flags_r;
      end else if (reg_hit(PADDR, BSW_IDX_PIN_CFG)) begin
         prdata_nxt[7:0] = pin_cfg_r;
      end else if (reg_hit(PADDR, BSW_IDX_DELTA_THR)) begin
         prdata_nxt[7:0] = delta_thr_r;
      end else if (reg_hit(PADDR, BSW_IDX_ADC_START)) begin
         prdata_nxt = 32'h0000_0000;
      end else if (reg_hit(PADDR, BSW_IDX_BAT_THR)) begin
         prdata_nxt[7:0] = bat_thr_r;
      end else if (reg_hit(PADDR, BSW_IDX_BAT_VALUE)) begin
         prdata_nxt[7:0] = bat_value_r;
      end else if (reg_hit(PADDR, BSW_IDX_DC_VALUE)) begin
         prdata_nxt[7:0] = dc_value_r;
      end else if (reg_hit(PADDR, BSW_IDX_DC_STATUS)) begin
         prdata_nxt[BSW_DC_READY_BIT] = dc_ready_r;
         prdata_nxt[BSW_BAT_LOW_BIT] = bat_value_r < bat_thr_r;
      end else begin
         pslverr_nxt = 1'b1;
      end
   end

   // Bus slave: one wait-free access cycle per transfer
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup_ph;
         PRDATA <= setup_ph ? prdata_nxt : 32'h0000_0000;
         PSLVERR <= setup_ph & pslverr_nxt;
      end
   end

   // Software registers
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         core_irq_en_r <= BSW_RST_CORE_IRQ_EN;
         event_en_r <= BSW_RST_EVENT_EN;
         peripheral_configuration_cfg_r <= BSW_RST_PERIPHERAL_CONFIGURATION_CFG;
         switch_cfg_r <= BSW_RST_SWITCH_CFG;
         pin_cfg_r <= BSW_RST_PIN_CFG;
         delta_thr_r <= BSW_RST_DELTA_THR;
         bat_thr_r <= BSW_RST_BAT_THR;
      end else begin
         if (wr_core_irq) core_irq_en_r <= wdata;
         if (wr_event_en) event_en_r <= wdata;
         if (wr_peripheral_configuration) peripheral_configuration_cfg_r <= wdata;
         if (wr_switch) switch_cfg_r <= wdata;
         if (wr_pin) pin_cfg_r <= wdata;
         if (wr_delta) delta_thr_r <= wdata;
         if (wr_bat_thr) bat_thr_r <= wdata;
      end
   end

   // Flags, measurements and background conversion timer
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         event_flags_r <= BSW_RST_EVENT_FLAGS;
         dc_ready_r <= 1'b0;
         bat_value_r <= 8'h00;
         dc_value_r <= 8'h00;
         dc_last_r <= 8'h00;
         bg_cnt_r <= 32'h0000_0000;
         ADC_START <= 1'b0;
      end else begin
         event_flags_r <= event_flags_nxt;
         dc_ready_r <= dc_ready_nxt;
         if (BAT_ADC_READY) bat_value_r <= BAT_ADC_VALUE;
         if (DCIN_ADC_READY) dc_value_r <= DCIN_ADC_VALUE;
         if (DCIN_ADC_READY) dc_last_r <= DCIN_ADC_VALUE;
         bg_cnt_r <= bg_wrap ? 32'h0000_0000 : bg_cnt_r + 32'd1;
         ADC_START <= adc_go_nxt;
      end
   end

   // Switchover state and registered supply outputs
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state_r <= BSW_ON_MAIN;
         wait_cnt_r <= 32'h0000_0000;
         ctl_pin_prev_r <= 1'b1;
         src_main_r <= 1'b1;
         SUPPLY_ON_MAIN <= 1'b1;
         METER_ADC_AVAILABLE <= 1'b1;
         SUPPLY_IRQ <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wait_cnt_r <= wait_cnt_nxt;
         ctl_pin_prev_r <= ctl_pin_s;
         src_main_r <= src_main_nxt;
         SUPPLY_ON_MAIN <= src_main_nxt;
         METER_ADC_AVAILABLE <= src_main_nxt;
         SUPPLY_IRQ <= irq_nxt;
      end
   end

   // Checks
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);

   sequence leave_main_s;
      src_main_r ##1 !src_main_r;
   endsequence

   sequence back_main_s;
      !src_main_r ##1 src_main_r;
   endsequence

   switch_flag_set_a: assert property (leave_main_s |-> event_flags_r[BSW_EV_SWITCH])
      else $error("switchover flag not set on move to battery");

   restore_flag_set_a: assert property (back_main_s |-> event_flags_r[BSW_EV_RESTORE])
      else $error("restored flag not set on return to main");

   disable_holds_main_a: assert property (sw_disabled ##1 sw_disabled |=> SUPPLY_ON_MAIN)
      else $error("supply left main while switchover disabled");

   source_status_read_a: assert property (
      setup_ph && reg_hit(PADDR, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG)
      |=> PRDATA[BSW_SRC_STATUS_BIT] == $past(src_main_r))
      else $error("source status bit disagrees with supply source");

   low_main_switch_a: assert property (
      state_r == BSW_ON_MAIN && !sw_disabled && !vdd_ok_s |=> state_r == BSW_ON_BAT ##1 !SUPPLY_ON_MAIN)
      else $error("low main supply did not move to battery");

   pin_edge_switch_a: assert property (
      state_r == BSW_ON_MAIN && !sw_disabled && ctl_pin_fall |=> state_r == BSW_ON_BAT)
      else $error("control pin falling edge did not move to battery");

   restore_needs_pin_a: assert property (
      state_r == BSW_RESTORING && pin_en && !sw_disabled |-> ctl_pin_s || state_nxt != BSW_ON_MAIN)
      else $error("return to main with control pin low");

   meter_follows_src_a: assert property (
      (state_r == BSW_ON_BAT || state_r == BSW_RESTORING) |-> !METER_ADC_AVAILABLE)
      else $error("metering ADC available while on battery");

   irq_master_gate_a: assert property (!core_irq_en_r[BSW_MASTER_EN_BIT] |=> !SUPPLY_IRQ)
      else $error("interrupt raised with master enable clear");

   irq_or_tie_a: assert property (
      core_irq_en_r[BSW_MASTER_EN_BIT] && (event_flags_r & event_en_r) != 8'h00 |=> SUPPLY_IRQ)
      else $error("enabled flag did not raise interrupt");

   flag_latched_a: assert property (
      event_flags_r[BSW_EV_SWITCH] && !wr_flags |=> event_flags_r[BSW_EV_SWITCH])
      else $error("switchover flag dropped without a clear");

   dcin_wait_bound_a: assert property (
      state_r == BSW_DCIN_WAIT && state_nxt == BSW_ON_BAT && !force_bat |-> dcin_done)
      else $error("dc-sense switchover before delay expired");

   restore_wait_bound_a: assert property (
      state_r == BSW_RESTORING && state_nxt == BSW_ON_MAIN && !sw_disabled |-> restore_done)
      else $error("return to main before restore delay expired");

   dc_low_flag_a: assert property (!dcin_ok_s |=> event_flags_r[BSW_EV_DC_LOW])
      else $error("dc-sense low flag not set");

endmodule

/* File: src/bsw_pkg.sv */
// Constants shared by the battery switchover and supply-monitor block.
// Assumes a 100 MHz core clock and an APB register bus with 32-bit data.
package bsw_pkg;

   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] BSW_IDX_CORE_IRQ_EN = 8'ha9;
   localparam logic [7:0] BSW_IDX_EVENT_EN = 8'hec;
   localparam logic [7:0] BSW_IDX_PERIPHERAL_CONFIGURATION_CFG = 8'hf4;
   localparam logic [7:0] BSW_IDX_SWITCH_CFG = 8'hf5;
   localparam logic [7:0] BSW_IDX_EVENT_FLAGS = 8'hf8;
   localparam logic [7:0] BSW_IDX_PIN_CFG = 8'hff;
   localparam logic [7:0] BSW_IDX_DELTA_THR = 8'hf3;
   localparam logic [7:0] BSW_IDX_ADC_START = 8'hd8;
   localparam logic [7:0] BSW_IDX_BAT_THR = 8'hfa;
   localparam logic [7:0] BSW_IDX_BAT_VALUE = 8'hdf;
   localparam logic [7:0] BSW_IDX_DC_VALUE = 8'hd9;
   localparam logic [7:0] BSW_IDX_DC_STATUS = 8'hda;

   // Event bit positions, shared by the flag and enable registers
   localparam int BSW_EV_BAT = 0;
   localparam int BSW_EV_DC_ADC = 1;
   localparam int BSW_EV_DC_LOW = 2;
   localparam int BSW_EV_SAG = 3;
   localparam int BSW_EV_RESTORE = 4;
   localparam int BSW_EV_SWITCH = 5;

   // Other field positions
   localparam int BSW_MASTER_EN_BIT = 1;
   localparam int BSW_SRC_STATUS_BIT = 6;
   localparam int BSW_SW_DISABLE_BIT = 1;
   localparam int BSW_SRC_SEL_LSB = 0;
   localparam int BSW_INT1_FN_LSB = 4;
   localparam int BSW_ADC_GO_BIT = 0;
   localparam int BSW_DC_READY_BIT = 0;
   localparam int BSW_BAT_LOW_BIT = 1;
   localparam logic [1:0] BSW_SEL_DCIN = 2'b01;
   localparam logic [1:0] BSW_INT1_FN_PIN = 2'b01;

   // Reset values
   localparam logic [7:0] BSW_RST_CORE_IRQ_EN = 8'h00;
   localparam logic [7:0] BSW_RST_EVENT_EN = 8'h00;
   localparam logic [7:0] BSW_RST_PERIPHERAL_CONFIGURATION_CFG = 8'h00;
   localparam logic [7:0] BSW_RST_SWITCH_CFG = 8'h00;
   localparam logic [7:0] BSW_RST_EVENT_FLAGS = 8'h00;
   localparam logic [7:0] BSW_RST_PIN_CFG = 8'h00;
   localparam logic [7:0] BSW_RST_DELTA_THR = 8'h00;
   localparam logic [7:0] BSW_RST_BAT_THR = 8'h00;

   // Timing
   localparam int unsigned BSW_CLK_HZ = 100_000_000;
   localparam int unsigned BSW_DCIN_DELAY_MS = 30;
   localparam int unsigned BSW_RESTORE_DELAY_MS = 130;
   localparam int unsigned BSW_BG_PERIOD_MS = 1;
   localparam int unsigned BSW_DCIN_DELAY_CYC = BSW_DCIN_DELAY_MS * (BSW_CLK_HZ / 1000);
   localparam int unsigned BSW_RESTORE_DELAY_CYC = BSW_RESTORE_DELAY_MS * (BSW_CLK_HZ / 1000);
   localparam int unsigned BSW_BG_PERIOD_CYC = BSW_BG_PERIOD_MS * (BSW_CLK_HZ / 1000);

   typedef enum logic [1:0] {
      BSW_ON_MAIN = 2'b00,
      BSW_ON_BAT = 2'b01,
      BSW_RESTORING = 2'b11,
      BSW_DCIN_WAIT = 2'b10
   } bsw_state_t;

endpackage

/* File: src/bsw_sync.sv */
// Two-flop synchroniser for the supply comparator and pin levels.
// Assumes inputs are quasi-static levels; reset value sets the idle reading.
`timescale 1ns/1ps
module bsw_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule

/* File: sim/bsw_far_side.sv */
// Far-side model: supply comparators, control pin, dc sense and battery ADCs, sag detector.
// Assumes the bench sets the analog levels and asks for battery and sag reports.
`timescale 1ns/1ps
module bsw_far_side (
   input wire logic clk,
   input wire logic adc_start,
   input wire logic vdd_ok_i,
   input wire logic dcin_ok_i,
   input wire logic pin_i,
   input wire logic [7:0] dc_val_i,
   input wire logic [7:0] bat_val_i,
   input wire logic bat_req,
   input wire logic sag_req,
   output logic vdd_ok,
   output logic dcin_ok,
   output logic pin,
   output logic dc_rdy,
   output logic [7:0] dc_val,
   output logic bat_rdy,
   output logic [7:0] bat_val,
   output logic sag
);
   logic [2:0] conv_r = '0;
   initial begin
      dc_rdy = 1'b0;
      dc_val = 8'h00;
      bat_rdy = 1'b0;
      bat_val = 8'h00;
      sag = 1'b0;
   end
   assign vdd_ok = vdd_ok_i;
   assign dcin_ok = dcin_ok_i;
   assign pin = pin_i;
   // Conversion takes four cycles; outside a result the value lines show its inverse
   always @(posedge clk) begin
      conv_r <= {conv_r[1:0], adc_start};
      dc_rdy <= conv_r[2];
      dc_val <= conv_r[2] ? dc_val_i : (dc_rdy ? ~dc_val : dc_val);
      bat_rdy <= bat_req;
      bat_val <= bat_req ? bat_val_i : (bat_rdy ? ~bat_val : bat_val);
      sag <= sag_req;
   end
endmodule

/* File: sim/tb_bsw_supply.sv */
// Self-checking bench for the switchover and supply-monitor block.
// Assumes shortened delay parameters and a one-clock design with APB registers.
`timescale 1ns/1ps
module tb_bsw_supply import bsw_pkg::*; ();
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic vdd_i = 1'b1;
   logic dcin_i = 1'b1;
   logic pin_i = 1'b1;
   logic bat_req = 1'b0;
   logic sag_req = 1'b0;
   logic [7:0] dc_val_i = 8'h00;
   logic [7:0] bat_val_i = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, on_main, meter_ok, adc_start, irq;
   logic vdd_ok, dcin_ok, pin, dc_rdy, bat_rdy, sag;
   logic [7:0] dc_val, bat_val, rv;
   logic err;
   int error_cnt = 0;
   int samples_checked = 0;

   always #5 clk_sys = ~clk_sys;

   bsw_supply #(.DCIN_DELAY_CYC(20), .RESTORE_DELAY_CYC(40), .BG_PERIOD_CYC(50)) i_bsw_supply (
      .CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .VDD_OK(vdd_ok), .DCIN_OK(dcin_ok), .BATTERY_CONTROL_PIN(pin),
      .DCIN_ADC_VALUE(dc_val), .DCIN_ADC_READY(dc_rdy), .BAT_ADC_VALUE(bat_val),
      .BAT_ADC_READY(bat_rdy), .LINE_SAG_EVENT(sag), .SUPPLY_ON_MAIN(on_main),
      .METER_ADC_AVAILABLE(meter_ok), .ADC_START(adc_start), .SUPPLY_IRQ(irq));

   bsw_far_side i_bsw_far_side (
      .clk(clk_sys), .adc_start(adc_start), .vdd_ok_i(vdd_i), .dcin_ok_i(dcin_i),
      .pin_i(pin_i), .dc_val_i(dc_val_i), .bat_val_i(bat_val_i), .bat_req(bat_req),
      .sag_req(sag_req), .vdd_ok(vdd_ok), .dcin_ok(dcin_ok), .pin(pin), .dc_rdy(dc_rdy),
      .dc_val(dc_val), .bat_rdy(bat_rdy), .bat_val(bat_val), .sag(sag));

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask

   task cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // One idle edge first, so a new setup never lands on the edge that released the last one
   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1);
      rv = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready wait", 1, n == 1);
   endtask

   task wait_main(input logic lvl, input int lim, output int n);
      n = 0;
      while (on_main !== lvl && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   task t_reset;
      chk("on main", 1, on_main);
      chk("irq", 0, irq);
      apb(0, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG, 8'h00);
      chk("source status", 8'h40, rv);
      apb(0, BSW_IDX_SWITCH_CFG, 8'h00);
      chk("switch cfg", BSW_RST_SWITCH_CFG, rv);
      apb(0, BSW_IDX_CORE_IRQ_EN, 8'h00);
      chk("master en", BSW_RST_CORE_IRQ_EN, rv);
      apb(0, 8'h10, 8'h00);
      chk("unmapped err", 1, err);
      apb(1, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG, 8'h00);
      apb(0, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG, 8'h00);
      chk("status read only", 8'h40, rv);
      $display("test reset done");
   endtask

   task t_vdd;
      int n;
      vdd_i <= 1'b0;
      wait_main(0, 20, n);
      chk("switch time", 1, n <= 6);
      chk("meter adc", 0, meter_ok);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("switch flag", 8'h20, rv);
      apb(0, BSW_IDX_PERIPHERAL_CONFIGURATION_CFG, 8'h00);
      chk("status battery", 8'h00, rv);
      apb(1, BSW_IDX_CORE_IRQ_EN, 8'h02);
      cyc(2);
      chk("irq event off", 0, irq);
      apb(1, BSW_IDX_EVENT_EN, 8'h20);
      cyc(2);
      chk("irq switch", 1, irq);
      apb(1, BSW_IDX_CORE_IRQ_EN, 8'h00);
      cyc(2);
      chk("irq master off", 0, irq);
      vdd_i <= 1'b1;
      wait_main(1, 80, n);
      chk("restore delay", 1, n >= 40 && n <= 50);
      chk("meter back", 1, meter_ok);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'hdf);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("restore flag kept", 8'h10, rv);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'h00);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("flags cleared", 8'h00, rv);
      apb(1, BSW_IDX_EVENT_EN, 8'h00);
      $display("test main supply loss done");
   endtask

   task t_dcin;
      int n;
      apb(1, BSW_IDX_SWITCH_CFG, 8'h01);
      dcin_i <= 1'b0;
      wait_main(0, 60, n);
      chk("dc sense delay", 1, n >= 20 && n <= 28);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("dc low flag", 1, rv[BSW_EV_DC_LOW]);
      cyc(60);
      chk("dc low holds battery", 0, on_main);
      dcin_i <= 1'b1;
      wait_main(1, 80, n);
      chk("dc restore delay", 1, n >= 40 && n <= 50);
      apb(1, BSW_IDX_SWITCH_CFG, 8'h00);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'h00);
      $display("test dc sense done");
   endtask

   task t_pin;
      int n;
      pin_i <= 1'b0;
      cyc(10);
      chk("pin ignored", 1, on_main);
      pin_i <= 1'b1;
      apb(1, BSW_IDX_PIN_CFG, 8'h10);
      pin_i <= 1'b0;
      wait_main(0, 20, n);
      chk("pin switch", 1, n <= 6);
      cyc(60);
      chk("pin low holds", 0, on_main);
      pin_i <= 1'b1;
      wait_main(1, 80, n);
      chk("pin restore", 1, n >= 40 && n <= 50);
      apb(1, BSW_IDX_PIN_CFG, 8'h00);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'h00);
      $display("test control pin done");
   endtask

   task t_disable;
      apb(1, BSW_IDX_SWITCH_CFG, 8'h02);
      vdd_i <= 1'b0;
      cyc(20);
      chk("disabled stays main", 1, on_main);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("no switch flag", 0, rv[BSW_EV_SWITCH]);
      vdd_i <= 1'b1;
      cyc(4);
      apb(1, BSW_IDX_SWITCH_CFG, 8'h00);
      $display("test disable done");
   endtask

   task t_adc;
      apb(1, BSW_IDX_DELTA_THR, 8'h10);
      dc_val_i <= 8'h40;
      apb(1, BSW_IDX_ADC_START, 8'h01);
      @(posedge clk_sys);
      chk("adc start", 1, adc_start);
      cyc(10);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("dc delta flag", 1, rv[BSW_EV_DC_ADC]);
      apb(0, BSW_IDX_DC_STATUS, 8'h00);
      chk("dc ready", 1, rv[BSW_DC_READY_BIT]);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'h00);
      dc_val_i <= 8'h48;
      apb(1, BSW_IDX_ADC_START, 8'h01);
      cyc(10);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("small delta", 0, rv[BSW_EV_DC_ADC]);
      apb(1, BSW_IDX_EVENT_EN, 8'h08);
      apb(1, BSW_IDX_CORE_IRQ_EN, 8'h02);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'h00);
      bat_val_i <= 8'h05;
      bat_req <= 1'b1;
      @(posedge clk_sys);
      bat_req <= 1'b0;
      cyc(4);
      chk("battery masked", 0, irq);
      apb(0, BSW_IDX_BAT_VALUE, 8'h00);
      chk("battery value", 8'h05, rv);
      apb(0, BSW_IDX_EVENT_FLAGS, 8'h00);
      chk("battery flag", 1, rv[BSW_EV_BAT]);
      sag_req <= 1'b1;
      @(posedge clk_sys);
      sag_req <= 1'b0;
      cyc(4);
      chk("sag irq", 1, irq);
      apb(1, BSW_IDX_EVENT_FLAGS, 8'h00);
      cyc(2);
      chk("irq after clear", 0, irq);
      $display("test adc and sag done");
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_reset;
      t_vdd;
      t_dcin;
      t_pin;
      t_disable;
      t_adc;
      end_sim;
   end

   // Whole run needs roughly 500 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      error_cnt++;
      end_sim;
   end
endmodule
